// ### dv/succ_tb.sv
`timescale 1ns/1ps
module succ_tb
   import succ_pkg::*;
;
   // ----------------------------------------
   // Clock, ports and counters
   // ----------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [SUCC_AW-1:0] wb_adr_i = 5'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [SUCC_DW-1:0] wb_dat_i = 32'h0, wb_dat_o;
   logic wb_ack_o, guard_protect_i = 1'b0, debug_access_i = 1'b0;
   logic erase_start_o, erase_done_i = 1'b0, bist_start_o;
   logic bist_done_i = 1'b0, bist_fail_i = 1'b0, mem_req_o, mem_ack_i = 1'b0;
   logic [31:0] mem_addr_o, mem_rdata_i = 32'h0, crc_next = 32'h100, exp_crc;
   logic soft_reset_o;
   int fail_count = 0, num_checks = 0, n_erase = 0, n_bist = 0, n_srst = 0;
   localparam logic [31:0] KEY = 32'h5A5A_0000;
   typedef struct {logic [3:0] sel; logic [31:0] wd;
                   logic [3:0] rsel; logic [31:0] exp;} succ_row_t;
   succ_row_t rows [6] = '{
      '{4'hF, 32'h1122_3344, 4'hF, 32'h1122_3344},
      '{4'h1, 32'h0000_00AA, 4'hF, 32'h1122_33AA},
      '{4'h2, 32'h0000_BB00, 4'h2, 32'h0000_BB00},
      '{4'hC, 32'hCCDD_0000, 4'hF, 32'hCCDD_BBAA},
      '{4'h3, 32'h0000_EEFF, 4'hC, 32'hCCDD_0000},
      '{4'h8, 32'h9900_0000, 4'hF, 32'h99DD_EEFF}};

   always #25 clk_i = ~clk_i;

   succ_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .guard_protect_i(guard_protect_i), .debug_access_i(debug_access_i),
      .erase_start_o(erase_start_o), .erase_done_i(erase_done_i),
      .bist_start_o(bist_start_o), .bist_done_i(bist_done_i), .bist_fail_i(bist_fail_i),
      .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_rdata_i(mem_rdata_i),
      .mem_ack_i(mem_ack_i), .soft_reset_o(soft_reset_o));

   // ----------------------------------------
   // Checking and bus tasks
   // ----------------------------------------
   task automatic finish_test();
      if (fail_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Single classic cycle; the bound only guards against a dead slave
   task automatic bus(input logic we, input logic [4:0] adr, input logic [3:0] sel,
                      input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= wd;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         fail_count++;
         $display("unexpected %0t bus timeout", $time);
         finish_test();
      end
   endtask

   task automatic wr(input logic [4:0] adr, input logic [3:0] sel, input logic [31:0] wd);
      logic [31:0] rd;
      bus(1'b1, adr, sel, wd, rd);
   endtask

   task automatic rd_chk(input logic [4:0] adr, input logic [3:0] sel, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, adr, sel, 32'h0, rd);
      check(rd, exp);
   endtask

   task automatic pulse_done(input logic fail);
      @(posedge clk_i);
      erase_done_i <= 1'b1;
      bist_done_i <= 1'b1;
      bist_fail_i <= fail;
      @(posedge clk_i);
      erase_done_i <= 1'b0;
      bist_done_i <= 1'b0;
      bist_fail_i <= 1'b0;
   endtask

   function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [31:0] d);
      for (int i = 0; i < 32; i++) begin
         c = (c >> 1) ^ ((c[0] ^ d[i]) ? SUCC_CRC_POLY : 32'h0);
      end
      return c;
   endfunction

   // ----------------------------------------
   // Strobe counters and memory responder
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (erase_start_o === 1'b1) n_erase++;
      if (bist_start_o === 1'b1) n_bist++;
      if (soft_reset_o === 1'b1) n_srst++;
      mem_ack_i <= (mem_req_o === 1'b1 && mem_ack_i === 1'b0);
      if (mem_req_o === 1'b1 && mem_ack_i === 1'b0) begin
         check(mem_addr_o, crc_next);
         mem_rdata_i <= mem_addr_o ^ KEY;
         crc_next = crc_next + 32'h4;
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] st;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         wr(5'h0C, rows[i].sel, rows[i].wd);
         rd_chk(5'h0C, rows[i].rsel, rows[i].exp);
      end
      // Second reset in mid-run, then reset values
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(5'h00, 4'hF, 32'h0);
      rd_chk(5'h04, 4'hF, 32'h0);
      rd_chk(5'h08, 4'hF, 32'h0);
      rd_chk(5'h0C, 4'hF, 32'h0);
      rd_chk(5'h10, 4'hF, 32'hFFFF_FFFF);
      rd_chk(5'h14, 4'hF, 32'h0);
      // Zeros and non-trigger lanes must do nothing
      wr(5'h00, 4'hF, 32'h0);
      wr(5'h00, 4'h1, 32'hE4);
      wr(5'h00, 4'hE, 32'hFFFF_FF00);
      repeat (3) @(posedge clk_i);
      check(32'(n_erase + n_bist + n_srst), 32'h0);
      rd_chk(5'h00, 4'hF, 32'h0);
      wr(5'h00, 4'h1, 32'h10);
      repeat (2) @(posedge clk_i);
      check(32'(n_erase), 32'h1);
      rd_chk(5'h00, 4'hF, 32'h4000);
      rd_chk(5'h00, 4'h1, 32'h0);
      wr(5'h00, 4'h1, 32'h10);
      repeat (2) @(posedge clk_i);
      check(32'(n_erase), 32'h1);
      pulse_done(1'b1);
      rd_chk(5'h00, 4'hF, 32'h0400);
      wr(5'h00, 4'h1, 32'h08);
      repeat (2) @(posedge clk_i);
      check(32'(n_bist), 32'h1);
      rd_chk(5'h00, 4'hF, 32'h2400);
      pulse_done(1'b1);
      rd_chk(5'h00, 4'hF, 32'h0E00);
      wr(5'h00, 4'h2, 32'h0800);
      rd_chk(5'h00, 4'hF, 32'h0600);
      // Two-word CRC pass
      wr(5'h08, 4'hF, 32'h100);
      wr(5'h0C, 4'hF, 32'h2);
      wr(5'h00, 4'h1, 32'h02);
      exp_crc = ~crc_upd(crc_upd(SUCC_CRC_SEED, 32'h100 ^ KEY), 32'h104 ^ KEY);
      st = 32'h0;
      for (int n = 0; n < 40 && st[8 + SUCC_ST_CRC_DONE] !== 1'b1; n++) begin
         bus(1'b0, 5'h00, 4'hF, 32'h0, st);
      end
      check(st, 32'h0700);
      check(crc_next, 32'h108);
      rd_chk(5'h10, 4'hF, exp_crc);
      // Guard blocks plain writes, debugger writes pass
      guard_protect_i <= 1'b1;
      rd_chk(5'h00, 4'hF, 32'h8700);
      wr(5'h08, 4'hF, 32'hAA);
      wr(5'h00, 4'h1, 32'h10);
      repeat (2) @(posedge clk_i);
      check(32'(n_erase), 32'h1);
      rd_chk(5'h08, 4'hF, 32'h100);
      debug_access_i <= 1'b1;
      wr(5'h08, 4'h1, 32'hAA);
      rd_chk(5'h08, 4'hF, 32'h1AA);
      wr(5'h0C, 4'hF, 32'h5);
      rd_chk(5'h0C, 4'hF, 32'h5);
      guard_protect_i <= 1'b0;
      debug_access_i <= 1'b0;
      // Enable low holds the bus answer back until it rises
      ce_i <= 1'b0;
      fork
         bus(1'b0, 5'h08, 4'hF, 32'h0, st);
         begin
            repeat (4) @(posedge clk_i);
            check(32'(wb_ack_o), 32'h0);
            ce_i <= 1'b1;
         end
      join
      check(st, 32'h1AA);
      // Soft reset wins over erase in the same write
      wr(5'h18, 4'hF, 32'hFF);
      rd_chk(5'h18, 4'hF, 32'h0);
      wr(5'h00, 4'h1, 32'h11);
      repeat (2) @(posedge clk_i);
      check(32'(n_srst), 32'h1);
      check(32'(n_erase), 32'h1);
      rd_chk(5'h00, 4'hF, 32'h0);
      rd_chk(5'h0C, 4'hF, 32'h0);
      rd_chk(5'h08, 4'hF, 32'h0);
      rd_chk(5'h10, 4'hF, 32'hFFFF_FFFF);
      finish_test();
   end
endmodule

// ### rtl/succ_crc32.sv
`timescale 1ns/1ps
module succ_crc32
   import succ_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Control
   input wire logic start_i,
   input wire logic abort_i,
   input wire logic [31:0] base_i,
   input wire logic [31:0] len_i,
   // Memory read port
   output logic mem_req_o,
   output logic [31:0] mem_addr_o,
   input wire logic [31:0] mem_rdata_i,
   input wire logic mem_ack_i,
   // Result
   output logic busy_o,
   output logic done_o,
   output logic [31:0] result_o
);

   succ_crc_state_t state;
   logic [31:0] crc;
   logic [31:0] remain;

   // Reflected CRC-32, one word per memory answer, low bit first
   function automatic logic [31:0] crc_word(input logic [31:0] c_in,
                                            input logic [31:0] d);
      logic [31:0] c;
      c = c_in;
      for (int i = 0; i < 32; i++) begin
         c = (c[0] ^ d[i]) ? ((c >> 1) ^ SUCC_CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

   assign mem_req_o = (state == SUCC_CRC_READ);
   assign busy_o = (state != SUCC_CRC_IDLE);

   // ----------------------------------------
   // Walker
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || (ce_i && abort_i)) begin
         state <= SUCC_CRC_IDLE;
         crc <= SUCC_CRC_SEED;
         remain <= SUCC_CRC_LEN_RST;
         mem_addr_o <= SUCC_CRC_ADDR_RST;
         done_o <= 1'b0;
         result_o <= SUCC_CRC_SEED;
      end else if (ce_i) begin
         done_o <= 1'b0;
         case (state)
            SUCC_CRC_IDLE: begin
               if (start_i) begin
                  crc <= SUCC_CRC_SEED;
                  remain <= len_i;
                  mem_addr_o <= base_i;
                  state <= (len_i == SUCC_CRC_LEN_RST) ? SUCC_CRC_DONE : SUCC_CRC_READ;
               end
            end
            SUCC_CRC_READ: begin
               if (mem_ack_i) begin
                  crc <= crc_word(crc, mem_rdata_i);
                  mem_addr_o <= mem_addr_o + SUCC_WORD_STEP;
                  remain <= remain - 32'h0000_0001;
                  if (remain == 32'h0000_0001) begin
                     state <= SUCC_CRC_DONE;
                  end
               end
            end
            SUCC_CRC_DONE: begin
               result_o <= ~crc;
               done_o <= 1'b1;
               state <= SUCC_CRC_IDLE;
            end
            default: state <= SUCC_CRC_IDLE;
         endcase
      end
   end

endmodule

// ### rtl/succ_op_track.sv
`timescale 1ns/1ps
module succ_op_track
   import succ_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Control
   input wire logic start_i,
   input wire logic abort_i,
   // Engine handshake
   output logic start_o,
   input wire logic done_i,
   input wire logic fail_i,
   // Result
   output logic busy_o,
   output logic done_o,
   output logic fail_o
);

   succ_op_state_t state;

   assign busy_o = (state == SUCC_OP_BUSY);

   // ----------------------------------------
   // Tracker
   // ----------------------------------------
   // Starts while busy are dropped, the engine takes one job at a time
   always_ff @(posedge clk_i) begin
      if (rst_i || (ce_i && abort_i)) begin
         state <= SUCC_OP_IDLE;
         start_o <= 1'b0;
         done_o <= 1'b0;
         fail_o <= 1'b0;
      end else if (ce_i) begin
         start_o <= 1'b0;
         done_o <= 1'b0;
         fail_o <= 1'b0;
         case (state)
            SUCC_OP_IDLE: begin
               if (start_i) begin
                  state <= SUCC_OP_BUSY;
                  start_o <= 1'b1;
               end
            end
            SUCC_OP_BUSY: begin
               if (done_i) begin
                  state <= SUCC_OP_IDLE;
                  done_o <= 1'b1;
                  fail_o <= fail_i;
               end
            end
            default: state <= SUCC_OP_IDLE;
         endcase
      end
   end

endmodule

// ### rtl/succ_pkg.sv
package succ_pkg;

   // ----------------------------------------
   // Bus geometry
   // ----------------------------------------
   localparam int SUCC_AW = 5;
   localparam int SUCC_DW = 32;

   // ----------------------------------------
   // Register indices, byte address is index times four
   // ----------------------------------------
   localparam logic [2:0] SUCC_IDX_CMD = 3'h0;
   localparam logic [2:0] SUCC_IDX_STAT = 3'h0;
   localparam logic [2:0] SUCC_IDX_CRC_ADDR = 3'h2;
   localparam logic [2:0] SUCC_IDX_CRC_LEN = 3'h3;
   localparam logic [2:0] SUCC_IDX_CRC_RES = 3'h4;
   // Status shares word 0 with the trigger byte, in lane 1
   localparam int SUCC_STAT_LANE = 1;

   // ----------------------------------------
   // Command trigger bits
   // ----------------------------------------
   localparam int SUCC_CMD_RST = 0;
   localparam int SUCC_CMD_CRC = 1;
   localparam int SUCC_CMD_BIST = 3;
   localparam int SUCC_CMD_ERASE = 4;

   // ----------------------------------------
   // Status bits
   // ----------------------------------------
   localparam int SUCC_ST_CRC_DONE = 0;
   localparam int SUCC_ST_BIST_DONE = 1;
   localparam int SUCC_ST_ERASE_DONE = 2;
   localparam int SUCC_ST_BIST_FAIL = 3;
   localparam int SUCC_ST_CRC_BUSY = 4;
   localparam int SUCC_ST_BIST_BUSY = 5;
   localparam int SUCC_ST_ERASE_BUSY = 6;
   localparam int SUCC_ST_GUARD = 7;

   // ----------------------------------------
   // Reset values and CRC constants
   // ----------------------------------------
   localparam logic [7:0] SUCC_CMD_RST_VAL = 8'h00;
   localparam logic [7:0] SUCC_STAT_RST_VAL = 8'h00;
   localparam logic [31:0] SUCC_CRC_ADDR_RST = 32'h0000_0000;
   localparam logic [31:0] SUCC_CRC_LEN_RST = 32'h0000_0000;
   localparam logic [31:0] SUCC_CRC_SEED = 32'hFFFF_FFFF;
   localparam logic [31:0] SUCC_CRC_POLY = 32'hEDB8_8320;
   localparam logic [31:0] SUCC_WORD_STEP = 32'h0000_0004;

   // ----------------------------------------
   // State types
   // ----------------------------------------
   typedef enum logic [1:0] {
      SUCC_CRC_IDLE = 2'b00,
      SUCC_CRC_READ = 2'b01,
      SUCC_CRC_DONE = 2'b10
   } succ_crc_state_t;

   typedef enum logic {
      SUCC_OP_IDLE = 1'b0,
      SUCC_OP_BUSY = 1'b1
   } succ_op_state_t;

   // Byte-lane merge shared by the CRC address and length registers
   function automatic logic [31:0] succ_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

endpackage

// ### rtl/succ_top.sv
// Contract
// - Writing one to bit 4 starts chip erase
// - Writing one to bit 3 starts memory self-test
// - Writing one to bit 1 starts CRC-32
// - Writing one to bit 0 resets the unit
// - Zeros written to trigger bits do nothing
// - Bank takes 8, 16 and 32-bit accesses
// - Bytes and halfwords reachable by byte enables
// - Guarded writes ignored while protection enabled
// - Debugger writes bypass the write guard
`timescale 1ns/1ps
module succ_top
   import succ_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [SUCC_AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [SUCC_DW-1:0] wb_dat_i,
   output logic [SUCC_DW-1:0] wb_dat_o,
   output logic wb_ack_o,
   // Access guard
   input wire logic guard_protect_i,
   input wire logic debug_access_i,
   // Chip erase engine
   output logic erase_start_o,
   input wire logic erase_done_i,
   // Memory self-test engine
   output logic bist_start_o,
   input wire logic bist_done_i,
   input wire logic bist_fail_i,
   // Memory read port for CRC
   output logic mem_req_o,
   output logic [31:0] mem_addr_o,
   input wire logic [31:0] mem_rdata_i,
   input wire logic mem_ack_i,
   // Soft reset strobe
   output logic soft_reset_o
);

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire [2:0] idx = wb_adr_i[4:2];
   wire req = wb_cyc_i && wb_stb_i;
   wire wr_fire = ce_i && req && wb_we_i && wb_ack_o;
   // Debugger traffic is never guarded
   wire wr_ok = wr_fire && (!guard_protect_i || debug_access_i);
   wire cmd_wr = wr_ok && (idx == SUCC_IDX_CMD) && wb_sel_i[0];
   wire stat_wr = wr_ok && (idx == SUCC_IDX_STAT) && wb_sel_i[SUCC_STAT_LANE];
   wire addr_wr = wr_ok && (idx == SUCC_IDX_CRC_ADDR);
   wire len_wr = wr_ok && (idx == SUCC_IDX_CRC_LEN);

   // Only ones act; reset in the same write wins over the starts
   wire cmd_rst = cmd_wr && wb_dat_i[SUCC_CMD_RST];
   wire cmd_crc = cmd_wr && wb_dat_i[SUCC_CMD_CRC] && !cmd_rst;
   wire cmd_bist = cmd_wr && wb_dat_i[SUCC_CMD_BIST] && !cmd_rst;
   wire cmd_erase = cmd_wr && wb_dat_i[SUCC_CMD_ERASE] && !cmd_rst;
   wire unit_rst = rst_i || (ce_i && cmd_rst);

   // ----------------------------------------
   // Registers and engine wires
   // ----------------------------------------
   logic [31:0] crc_addr;
   logic [31:0] crc_len;
   logic [31:0] crc_result;
   logic crc_done_flag;
   logic bist_done_flag;
   logic erase_done_flag;
   logic bist_fail_flag;
   logic crc_busy;
   logic crc_done;
   logic bist_busy;
   logic bist_done;
   logic bist_fail;
   logic erase_busy;
   logic erase_done;

   // ----------------------------------------
   // Engines
   // ----------------------------------------
   succ_crc32 u_crc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .start_i(cmd_crc),
      .abort_i(cmd_rst),
      .base_i(crc_addr),
      .len_i(crc_len),
      .mem_req_o(mem_req_o),
      .mem_addr_o(mem_addr_o),
      .mem_rdata_i(mem_rdata_i),
      .mem_ack_i(mem_ack_i),
      .busy_o(crc_busy),
      .done_o(crc_done),
      .result_o(crc_result)
   );

   succ_op_track u_bist (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .start_i(cmd_bist),
      .abort_i(cmd_rst),
      .start_o(bist_start_o),
      .done_i(bist_done_i),
      .fail_i(bist_fail_i),
      .busy_o(bist_busy),
      .done_o(bist_done),
      .fail_o(bist_fail)
   );

   succ_op_track u_erase (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .start_i(cmd_erase),
      .abort_i(cmd_rst),
      .start_o(erase_start_o),
      .done_i(erase_done_i),
      .fail_i(1'b0),
      .busy_o(erase_busy),
      .done_o(erase_done),
      .fail_o()
   );

   // ----------------------------------------
   // Read selection
   // ----------------------------------------
   wire [7:0] status = {guard_protect_i, erase_busy, bist_busy, crc_busy,
                        bist_fail_flag, erase_done_flag, bist_done_flag, crc_done_flag};
   // Trigger register is write-only and always reads zero
   // Status sits in lane 1 of the trigger word
   wire [31:0] rd_word =
      (idx == SUCC_IDX_CMD) ? {16'h0000, status, SUCC_CMD_RST_VAL} :
      (idx == SUCC_IDX_CRC_ADDR) ? crc_addr :
      (idx == SUCC_IDX_CRC_LEN) ? crc_len :
      (idx == SUCC_IDX_CRC_RES) ? crc_result : 32'h0000_0000;
   // Unselected lanes read zero so narrow reads stay clean
   wire [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // ----------------------------------------
   // Bus answer
   // ----------------------------------------
   // One wait state: ack follows the request edge, drops the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         wb_ack_o <= req && !wb_ack_o;
         wb_dat_o <= (req && !wb_ack_o && !wb_we_i) ? (rd_word & lane_mask) : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (unit_rst) begin
         crc_addr <= SUCC_CRC_ADDR_RST;
         crc_len <= SUCC_CRC_LEN_RST;
      end else if (ce_i) begin
         if (addr_wr) begin
            crc_addr <= succ_merge(crc_addr, wb_dat_i, wb_sel_i);
         end
         if (len_wr) begin
            crc_len <= succ_merge(crc_len, wb_dat_i, wb_sel_i);
         end
      end
   end

   // ----------------------------------------
   // Completion flags
   // ----------------------------------------
   // Write one to clear; a completion in the clear cycle still sets
   wire [3:0] clr = stat_wr ? wb_dat_i[SUCC_STAT_LANE*8 +: 4] : 4'h0;
   always_ff @(posedge clk_i) begin
      if (unit_rst) begin
         crc_done_flag <= SUCC_STAT_RST_VAL[SUCC_ST_CRC_DONE];
         bist_done_flag <= SUCC_STAT_RST_VAL[SUCC_ST_BIST_DONE];
         erase_done_flag <= SUCC_STAT_RST_VAL[SUCC_ST_ERASE_DONE];
         bist_fail_flag <= SUCC_STAT_RST_VAL[SUCC_ST_BIST_FAIL];
      end else if (ce_i) begin
         crc_done_flag <= crc_done || (crc_done_flag && !clr[SUCC_ST_CRC_DONE]);
         bist_done_flag <= bist_done || (bist_done_flag && !clr[SUCC_ST_BIST_DONE]);
         erase_done_flag <= erase_done || (erase_done_flag && !clr[SUCC_ST_ERASE_DONE]);
         bist_fail_flag <= bist_fail || (bist_fail_flag && !clr[SUCC_ST_BIST_FAIL]);
      end
   end

   // ----------------------------------------
   // Soft reset strobe
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         soft_reset_o <= 1'b0;
      end else if (ce_i) begin
         soft_reset_o <= cmd_rst;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_cmd_one(int b);
      ce_i && cmd_wr && wb_dat_i[b] && !wb_dat_i[SUCC_CMD_RST];
   endsequence

   sequence s_guarded_addr_wr;
      wr_fire && guard_protect_i && !debug_access_i && (idx == SUCC_IDX_CRC_ADDR);
   endsequence

   sequence s_guarded_cmd_wr;
      wr_fire && guard_protect_i && !debug_access_i && (idx == SUCC_IDX_CMD) && wb_sel_i[0];
   endsequence

   a_erase_start: assert property (
      s_cmd_one(SUCC_CMD_ERASE) ##0 !erase_busy |=> erase_start_o && erase_busy)
      else $error("erase not started by trigger write");

   a_bist_start: assert property (
      s_cmd_one(SUCC_CMD_BIST) ##0 !bist_busy
      |=> bist_start_o ##1 (!bist_start_o || !$past(ce_i)))
      else $error("self-test start strobe wrong");

   a_crc_start: assert property (
      s_cmd_one(SUCC_CMD_CRC) ##0 !crc_busy |=> crc_busy)
      else $error("crc not started by trigger write");

   a_soft_reset: assert property (
      ce_i && cmd_rst |=> soft_reset_o && !crc_busy && !bist_busy && !erase_busy
                          && crc_addr == SUCC_CRC_ADDR_RST && status[3:0] == 4'h0)
      else $error("soft reset did not clear the unit");

   a_zero_noop: assert property (
      ce_i && cmd_wr && wb_dat_i[4:0] == 5'h00 && !erase_busy && !bist_busy
      |=> !erase_start_o && !bist_start_o && !soft_reset_o && $stable(crc_addr))
      else $error("zero trigger write had an effect");

   a_ack_single: assert property (
      ce_i && req && !wb_ack_o |=> wb_ack_o ##1 (!wb_ack_o || !$past(ce_i)))
      else $error("ack not a single-cycle answer");

   a_byte_lane: assert property (
      ce_i && addr_wr && wb_sel_i == 4'h1 && !cmd_rst
      |=> crc_addr[31:8] == $past(crc_addr[31:8]) && crc_addr[7:0] == $past(wb_dat_i[7:0]))
      else $error("byte write touched other lanes");

   a_guard_block: assert property (
      s_guarded_addr_wr |=> $stable(crc_addr))
      else $error("guarded write took effect");

   a_debug_bypass: assert property (
      ce_i && wr_fire && guard_protect_i && debug_access_i && idx == SUCC_IDX_CRC_LEN
      && wb_sel_i == 4'hF |=> crc_len == $past(wb_dat_i))
      else $error("debugger write was blocked");

   a_cmd_reads_zero: assert property (
      wb_ack_o && !wb_we_i && idx == SUCC_IDX_CMD |-> wb_dat_o[7:0] == 8'h00)
      else $error("trigger register read nonzero");

   a_done_sticky: assert property (
      ce_i && crc_done && !cmd_rst |=> crc_done_flag)
      else $error("crc completion not reported");

   a_guard_cmd: assert property (
      s_guarded_cmd_wr |=> !erase_start_o && !bist_start_o && !soft_reset_o)
      else $error("guarded trigger write took effect");

   // Fail travels with the done pulse, never later
   a_fail_report: assert property (
      ce_i && bist_busy && bist_done_i && bist_fail_i && !cmd_rst |=> bist_fail && bist_done)
      else $error("self-test failure not reported");

   a_flag_clear: assert property (
      ce_i && clr[SUCC_ST_BIST_FAIL] && !bist_fail |=> !bist_fail_flag)
      else $error("fail flag not cleared by write of one");

   a_strobe_single: assert property (
      ce_i && (erase_start_o || bist_start_o) |=> !erase_start_o && !bist_start_o)
      else $error("start strobe longer than one cycle");

   // Enable low must hold every flop, the bus answer included
   a_ce_freeze: assert property (
      !ce_i |=> $stable(wb_ack_o) && $stable(soft_reset_o) && $stable(crc_addr))
      else $error("state moved while clock enable was low");

   a_unmapped_read: assert property (
      wb_ack_o && !wb_we_i && idx > SUCC_IDX_CRC_RES |-> wb_dat_o == 32'h0000_0000)
      else $error("unmapped register read nonzero");

endmodule
